// *** verilog/prc_defs.svh ***
`ifndef PRC_DEFS_SVH
`define PRC_DEFS_SVH

// clock
`define PRC_CLK_NS          20

// timing, in ns, and derived least cycle counts
`define PRC_POR_WIDTH_NS    1000
`define PRC_WARM_WIDTH_NS   150
`define PRC_READY_NS        120
`define PRC_CFG_LOAD_NS     300
`define PRC_POR_WIDTH_CYC   ((`PRC_POR_WIDTH_NS + `PRC_CLK_NS - 1) / `PRC_CLK_NS)
`define PRC_WARM_WIDTH_CYC  ((`PRC_WARM_WIDTH_NS + `PRC_CLK_NS - 1) / `PRC_CLK_NS)
`define PRC_READY_CYC       ((`PRC_READY_NS + `PRC_CLK_NS - 1) / `PRC_CLK_NS)
`define PRC_CFG_LOAD_CYC    ((`PRC_CFG_LOAD_NS + `PRC_CLK_NS - 1) / `PRC_CLK_NS)
`define PRC_STROBE_CYC      2

// register offsets
`define PRC_OFS_PMR0        8'h00
`define PRC_OFS_GATE        8'h01
`define PRC_OFS_JTAG        8'h02
`define PRC_OFS_GPIO_DATA   8'h03
`define PRC_OFS_GPIO_DIR    8'h04
`define PRC_OFS_PINS        8'h05
`define PRC_OFS_STATUS      8'h06

// reset values and writable masks
`define PRC_REG_RESET       8'h00
`define PRC_PMR0_MASK       8'h38
`define PRC_GATE_MASK       8'h7C

// power_mode_reg_zero fields
`define PRC_TURBO_OFF_BIT   3
`define PRC_ARR_CLK_BLK_BIT 4
`define PRC_MC_CLK_BLK_BIT  5

// pld_input_gate_reg fields
`define PRC_BLK_WR_BIT      2
`define PRC_BLK_RD_BIT      3
`define PRC_BLK_CTL3_BIT    4
`define PRC_BLK_PDZ_BIT     5
`define PRC_BLK_PCS_BIT     6

// jtag control register field
`define PRC_JTAG_EN_BIT     0

// port c pin roles
`define PRC_PIN_TMS         0
`define PRC_PIN_TCK         1
`define PRC_PIN_STAT        3
`define PRC_PIN_ERR         4
`define PRC_PIN_TDI         5
`define PRC_PIN_TDO         6
`define PRC_PIN_PCS         7

`endif

// *** verilog/prc_pkg.sv ***
package prc_pkg;
   typedef logic [7:0] prc_byte_t;

   typedef enum logic [1:0] {
      PRC_LOAD  = 2'b00,
      PRC_HOLD  = 2'b01,
      PRC_WAIT  = 2'b10,
      PRC_READY = 2'b11
   } prc_seq_e;

   typedef enum logic [2:0] {
      PRC_H_POR    = 3'b000,
      PRC_H_WAIT   = 3'b001,
      PRC_H_IDLE   = 3'b010,
      PRC_H_SETUP  = 3'b011,
      PRC_H_STROBE = 3'b100,
      PRC_H_HOLD   = 3'b101,
      PRC_H_WARM   = 3'b110
   } prc_host_e;
endpackage

// *** verilog/prc_bus_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface prc_bus_if;
   import prc_pkg::*;
   logic      reset_n;
   logic      cs_n;
   logic      write_control_in_n;
   logic      read_control_in_n;
   logic      third_control_in;
   prc_byte_t addr;
   prc_byte_t wdata;
   prc_byte_t rdata;
   logic      rdata_oe;
   prc_byte_t flash_sector_selects;

   modport dev (
      input  reset_n,
      input  cs_n,
      input  write_control_in_n,
      input  read_control_in_n,
      input  third_control_in,
      input  addr,
      input  wdata,
      input  flash_sector_selects,
      output rdata,
      output rdata_oe
   );

   modport host (
      output reset_n,
      output cs_n,
      output write_control_in_n,
      output read_control_in_n,
      output third_control_in,
      output addr,
      output wdata,
      output flash_sector_selects,
      input  rdata,
      input  rdata_oe
   );
endinterface
`default_nettype wire

// *** verilog/prc_dev_end.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "prc_defs.svh"
module prc_dev_end (
   input  wire logic              CLK_SYS,
   input  wire logic              RST_N,
   prc_bus_if.dev                 BUS,
   input  wire logic              PLD_CLOCK_INPUT,
   input  wire logic              PORTD_PIN_ZERO,
   input  wire prc_pkg::prc_byte_t PORTC_IN,
   input  wire logic              CFG_JTAG_PINS,
   input  wire logic              PLD_JTAG_TERM,
   input  wire logic              PROG_EXT_EN,
   input  wire logic              PROG_STATUS_N,
   input  wire logic              PROG_ERROR_N,
   input  wire prc_pkg::prc_byte_t MCELL_D,
   input  wire prc_pkg::prc_byte_t MCELL_RESET,
   input  wire prc_pkg::prc_byte_t MCELL_PRESET,
   output logic                   PORTC_OUT_0,
   output prc_pkg::prc_byte_t     PORTC_OUT,
   output prc_pkg::prc_byte_t     PORTC_OE,
   output logic                   PLD_WRITE_CTL_N,
   output logic                   PLD_READ_CTL_N,
   output logic                   PLD_THIRD_CTL,
   output logic                   PLD_PORTD_ZERO,
   output logic                   PLD_PORTC_SEVEN,
   output logic                   PLD_ARRAY_CLK,
   output logic                   PLD_TURBO_ON,
   output logic                   PLD_OUT_VALID,
   output prc_pkg::prc_byte_t     MCELL_Q,
   output logic                   FLASH_SEL,
   output logic                   FLASH_STANDBY,
   output logic                   FLASH_WR_N,
   output logic                   FLASH_RD_N,
   output logic                   FLASH_READ_ARRAY,
   output logic                   JTAG_ON,
   output logic                   DEV_READY
);
   import prc_pkg::*;

   prc_seq_e  seq_q, seq_d;
   logic [15:0] cnt_q, cnt_d;
   logic      cfg_q, cfg_d;
   logic      fra_q, fra_d;
   prc_byte_t pmr0_q, pmr0_d;
   prc_byte_t gate_q, gate_d;
   prc_byte_t gpio_q, gpio_d;
   prc_byte_t dir_q, dir_d;
   prc_byte_t rdata_q, rdata_d;
   logic      jen_q, jen_d;
   logic      wr_n_q, tck_q, pclk_q, byp_q, byp_d, tdo_q, tdo_d;
   prc_byte_t mc_q, mc_d;
   logic      acc_ok, wr_fall, any_rst, mc_edge, tck_rise, tck_fall;

   // startup and reset sequencing
   always_comb begin
      seq_d = seq_q;
      cnt_d = cnt_q;
      cfg_d = cfg_q;
      fra_d = fra_q;
      unique case (seq_q)
         PRC_LOAD: begin
            if (cnt_q == 16'(`PRC_CFG_LOAD_CYC - 1)) begin
               cfg_d = 1'b1;
               cnt_d = 16'h0000;
               seq_d = PRC_HOLD;
            end else begin
               cnt_d = cnt_q + 16'h0001;
            end
         end
         PRC_HOLD: begin
            cnt_d = 16'h0000;
            if (BUS.reset_n) begin
               seq_d = PRC_WAIT;
            end
         end
         PRC_WAIT: begin
            if (!BUS.reset_n) begin
               seq_d = PRC_HOLD;
            end else if (cnt_q == 16'(`PRC_READY_CYC - 1)) begin
               seq_d = PRC_READY;
            end else begin
               cnt_d = cnt_q + 16'h0001;
            end
         end
         PRC_READY: begin
            if (!BUS.reset_n) begin
               seq_d = PRC_HOLD;
            end
         end
      endcase
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         seq_q <= PRC_LOAD;
         cnt_q <= 16'h0000;
         cfg_q <= 1'b0;
         fra_q <= 1'b1;
      end else begin
         seq_q <= seq_d;
         cnt_q <= cnt_d;
         cfg_q <= cfg_d;
         fra_q <= fra_d;
      end
   end

   // register access, gated by chip select and readiness
   assign acc_ok  = ~BUS.cs_n & (seq_q == PRC_READY);
   assign wr_fall = wr_n_q & ~BUS.write_control_in_n & acc_ok;
   assign any_rst = ~BUS.reset_n;

   always_comb begin
      pmr0_d = pmr0_q;
      gate_d = gate_q;
      gpio_d = gpio_q;
      dir_d  = dir_q;
      jen_d  = jen_q;
      if (any_rst) begin
         gpio_d = `PRC_REG_RESET;
         dir_d  = `PRC_REG_RESET;
         jen_d  = 1'b0;
      end else if (wr_fall) begin
         case (BUS.addr)
            `PRC_OFS_PMR0: pmr0_d = BUS.wdata & `PRC_PMR0_MASK;
            `PRC_OFS_GATE: gate_d = BUS.wdata & `PRC_GATE_MASK;
            `PRC_OFS_JTAG: jen_d  = BUS.wdata[`PRC_JTAG_EN_BIT];
            `PRC_OFS_GPIO_DATA: gpio_d = BUS.wdata;
            `PRC_OFS_GPIO_DIR:  dir_d  = BUS.wdata;
            default: ;
         endcase
      end
      case (BUS.addr)
         `PRC_OFS_PMR0:      rdata_d = pmr0_q;
         `PRC_OFS_GATE:      rdata_d = gate_q;
         `PRC_OFS_JTAG:      rdata_d = {7'h00, jen_q};
         `PRC_OFS_GPIO_DATA: rdata_d = gpio_q;
         `PRC_OFS_GPIO_DIR:  rdata_d = dir_q;
         `PRC_OFS_PINS:      rdata_d = PORTC_IN;
         `PRC_OFS_STATUS:    rdata_d = {6'h00, cfg_q, DEV_READY};
         default:            rdata_d = 8'h00;
      endcase
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         pmr0_q  <= `PRC_REG_RESET;
         gate_q  <= `PRC_REG_RESET;
         gpio_q  <= `PRC_REG_RESET;
         dir_q   <= `PRC_REG_RESET;
         jen_q   <= 1'b0;
         rdata_q <= 8'h00;
         wr_n_q  <= 1'b1;
      end else begin
         pmr0_q  <= pmr0_d;
         gate_q  <= gate_d;
         gpio_q  <= gpio_d;
         dir_q   <= dir_d;
         jen_q   <= jen_d;
         rdata_q <= rdata_d;
         wr_n_q  <= BUS.write_control_in_n;
      end
   end

   assign BUS.rdata    = rdata_q;
   assign BUS.rdata_oe = acc_ok & ~BUS.read_control_in_n;
   assign DEV_READY    = (seq_q == PRC_READY);

   // flash path: strobes never blocked, cs and readiness gate access only
   assign FLASH_WR_N       = BUS.write_control_in_n;
   assign FLASH_RD_N       = BUS.read_control_in_n;
   assign FLASH_SEL        = acc_ok;
   assign FLASH_STANDBY    = BUS.cs_n;
   assign FLASH_READ_ARRAY = fra_q;

   // pld input gating, independent of chip select
   assign PLD_TURBO_ON    = ~pmr0_q[`PRC_TURBO_OFF_BIT];
   assign PLD_ARRAY_CLK   = pmr0_q[`PRC_ARR_CLK_BLK_BIT] ? 1'b0
                                 : PLD_CLOCK_INPUT;
   assign PLD_WRITE_CTL_N = gate_q[`PRC_BLK_WR_BIT] ? 1'b1
                                 : BUS.write_control_in_n;
   assign PLD_READ_CTL_N  = gate_q[`PRC_BLK_RD_BIT] ? 1'b1
                                 : BUS.read_control_in_n;
   assign PLD_THIRD_CTL   = gate_q[`PRC_BLK_CTL3_BIT] ? 1'b0
                                 : BUS.third_control_in;
   assign PLD_PORTD_ZERO  = gate_q[`PRC_BLK_PDZ_BIT] ? 1'b0
                                 : PORTD_PIN_ZERO;
   assign PLD_PORTC_SEVEN = gate_q[`PRC_BLK_PCS_BIT] ? 1'b0
                                 : PORTC_IN[`PRC_PIN_PCS];
   assign PLD_OUT_VALID   = cfg_q;

   // output macrocells
   assign mc_edge = PLD_CLOCK_INPUT & ~pclk_q
                    & ~pmr0_q[`PRC_MC_CLK_BLK_BIT];

   always_comb begin
      if (!cfg_q) begin
         mc_d = 8'h00;
      end else begin
         mc_d = ((mc_edge ? MCELL_D : mc_q) | MCELL_PRESET)
                & ~MCELL_RESET;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         mc_q   <= 8'h00;
         pclk_q <= 1'b0;
      end else begin
         mc_q   <= mc_d;
         pclk_q <= PLD_CLOCK_INPUT;
      end
   end

   assign MCELL_Q = mc_q;

   // jtag: isp only, single-bit bypass path
   assign JTAG_ON  = CFG_JTAG_PINS | PLD_JTAG_TERM | jen_q;
   assign tck_rise = PORTC_IN[`PRC_PIN_TCK] & ~tck_q;
   assign tck_fall = ~PORTC_IN[`PRC_PIN_TCK] & tck_q;

   always_comb begin
      byp_d = byp_q;
      tdo_d = tdo_q;
      if (JTAG_ON && tck_rise) begin
         byp_d = PORTC_IN[`PRC_PIN_TDI];
      end
      if (JTAG_ON && tck_fall) begin
         tdo_d = byp_q;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         tck_q <= 1'b1; // tck idles high on its pull-up
         byp_q <= 1'b0;
         tdo_q <= 1'b1;
      end else begin
         tck_q <= PORTC_IN[`PRC_PIN_TCK];
         byp_q <= byp_d;
         tdo_q <= tdo_d;
      end
   end

   // port c pin muxing
   for (genvar i = 0; i < 8; i++) begin : g_pin
      logic pin_o;
      logic pin_e;
      always_comb begin
         pin_o = gpio_q[i];
         pin_e = dir_q[i];
         if (JTAG_ON && (i == `PRC_PIN_TMS || i == `PRC_PIN_TCK
                         || i == `PRC_PIN_TDI)) begin
            pin_o = 1'b0;
            pin_e = 1'b0;
         end else if (JTAG_ON && i == `PRC_PIN_TDO) begin
            pin_o = tdo_q;
            pin_e = 1'b1;
         end else if (JTAG_ON && PROG_EXT_EN && i == `PRC_PIN_STAT) begin
            pin_o = 1'b0;
            pin_e = ~PROG_STATUS_N;
         end else if (JTAG_ON && PROG_EXT_EN && i == `PRC_PIN_ERR) begin
            pin_o = 1'b0;
            pin_e = ~PROG_ERROR_N;
         end
      end
      assign PORTC_OUT[i] = pin_o;
      assign PORTC_OE[i]  = pin_e;
   end

   assign PORTC_OUT_0 = PORTC_OUT[`PRC_PIN_TMS];

endmodule // prc_dev_end
`default_nettype wire

// *** verilog/prc_host_end.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "prc_defs.svh"
module prc_host_end (
   input  wire logic               CLK_SYS,
   input  wire logic               RST_N,
   prc_bus_if.host                 BUS,
   input  wire logic               CMD_REQ,
   input  wire logic               CMD_WE,
   input  wire prc_pkg::prc_byte_t CMD_ADDR,
   input  wire prc_pkg::prc_byte_t CMD_WDATA,
   input  wire logic               WARM_REQ,
   output logic                    CMD_READY,
   output logic                    CMD_DONE,
   output prc_pkg::prc_byte_t      CMD_RDATA
);
   import prc_pkg::*;

   prc_host_e   st_q, st_d;
   logic [15:0] cnt_q, cnt_d;
   prc_byte_t   addr_q, addr_d, wdata_q, wdata_d, rdata_q, rdata_d;
   logic        we_q, we_d, done_q, done_d;

   always_comb begin
      st_d    = st_q;
      cnt_d   = cnt_q + 16'h0001;
      addr_d  = addr_q;
      wdata_d = wdata_q;
      we_d    = we_q;
      rdata_d = rdata_q;
      done_d  = 1'b0;
      unique case (st_q)
         PRC_H_POR: begin
            if (cnt_q == 16'(`PRC_POR_WIDTH_CYC - 1)) begin
               st_d  = PRC_H_WAIT;
               cnt_d = 16'h0000;
            end
         end
         PRC_H_WARM: begin
            if (cnt_q == 16'(`PRC_WARM_WIDTH_CYC - 1)) begin
               st_d  = PRC_H_WAIT;
               cnt_d = 16'h0000;
            end
         end
         PRC_H_WAIT: begin
            if (cnt_q == 16'(`PRC_READY_CYC + 1)) begin
               st_d = PRC_H_IDLE;
            end
         end
         PRC_H_IDLE: begin
            cnt_d = 16'h0000;
            if (WARM_REQ) begin
               st_d = PRC_H_WARM;
            end else if (CMD_REQ) begin
               st_d    = PRC_H_SETUP;
               addr_d  = CMD_ADDR;
               we_d    = CMD_WE;
               wdata_d = CMD_WDATA;
               if (CMD_ADDR == `PRC_OFS_GATE) begin
                  wdata_d = CMD_WDATA & `PRC_GATE_MASK;
               end else if (CMD_ADDR == `PRC_OFS_PMR0) begin
                  wdata_d = CMD_WDATA & `PRC_PMR0_MASK;
               end
            end
         end
         PRC_H_SETUP: begin
            st_d  = PRC_H_STROBE;
            cnt_d = 16'h0000;
         end
         PRC_H_STROBE: begin
            if (cnt_q == 16'(`PRC_STROBE_CYC - 1)) begin
               st_d = PRC_H_HOLD;
               if (!we_q) begin
                  rdata_d = BUS.rdata;
               end
            end
         end
         PRC_H_HOLD: begin
            st_d   = PRC_H_IDLE;
            done_d = 1'b1;
         end
         default: begin
            st_d  = PRC_H_POR;
            cnt_d = 16'h0000;
         end
      endcase
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         st_q    <= PRC_H_POR;
         cnt_q   <= 16'h0000;
         addr_q  <= 8'h00;
         wdata_q <= 8'h00;
         we_q    <= 1'b0;
         rdata_q <= 8'h00;
         done_q  <= 1'b0;
      end else begin
         st_q    <= st_d;
         cnt_q   <= cnt_d;
         addr_q  <= addr_d;
         wdata_q <= wdata_d;
         we_q    <= we_d;
         rdata_q <= rdata_d;
         done_q  <= done_d;
      end
   end

   assign BUS.reset_n = ~(st_q == PRC_H_POR || st_q == PRC_H_WARM);
   assign BUS.cs_n    = ~(st_q == PRC_H_SETUP || st_q == PRC_H_STROBE
                          || st_q == PRC_H_HOLD);
   assign BUS.write_control_in_n = ~(st_q == PRC_H_STROBE & we_q);
   assign BUS.read_control_in_n  = ~(st_q == PRC_H_STROBE & ~we_q);
   assign BUS.third_control_in     = 1'b0;
   assign BUS.flash_sector_selects = 8'h00;
   assign BUS.addr  = addr_q;
   assign BUS.wdata = wdata_q;
   assign CMD_READY = (st_q == PRC_H_IDLE);
   assign CMD_DONE  = done_q;
   assign CMD_RDATA = rdata_q;

endmodule // prc_host_end
`default_nettype wire

// *** sim/prc_link_chk.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "prc_defs.svh"
module prc_link_chk (
   input  wire logic               CLK_SYS,
   input  wire logic               RST_N,
   input  wire logic               reset_n,
   input  wire logic               cs_n,
   input  wire logic               write_control_in_n,
   input  wire logic               read_control_in_n,
   input  wire logic               rdata_oe,
   input  wire prc_pkg::prc_byte_t flash_sector_selects
);
   import prc_pkg::*;
   localparam int POR_MIN = `PRC_POR_WIDTH_CYC;
   logic [7:0] low_cnt_q;
   logic [7:0] low_cnt_d;
   logic       first_q;
   logic       first_d;
   // low cycles of the device reset pin, first pulse flag
   always_comb begin
      low_cnt_d = reset_n ? 8'h00 : low_cnt_q + {7'h00, low_cnt_q != 8'hFF};
      first_d   = first_q & ~reset_n;
   end
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         low_cnt_q <= 8'h00;
         first_q   <= 1'b1;
      end else begin
         low_cnt_q <= low_cnt_d;
         first_q   <= first_d;
      end
   end
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RST_N);
   property p_oe_cause;
      rdata_oe |-> !cs_n && !read_control_in_n;
   endproperty
   a_oe_cause: assert property (p_oe_cause)
      else $error("read data driven without select and strobe");
   property p_oe_read;
      $fell(read_control_in_n) |-> rdata_oe [*2] ##1 !rdata_oe;
   endproperty
   a_oe_read: assert property (p_oe_read)
      else $error("read data not driven for the strobe");
   property p_sel_low;
      flash_sector_selects == 8'h00;
   endproperty
   a_sel_low: assert property (p_sel_low)
      else $error("sector select active");
   property p_wr_idle_rst;
      !reset_n |-> write_control_in_n && read_control_in_n && cs_n;
   endproperty
   a_wr_idle_rst: assert property (p_wr_idle_rst)
      else $error("access during device reset");
   property p_por_width;
      $rose(reset_n) && first_q |-> low_cnt_q >= POR_MIN;
   endproperty
   a_por_width: assert property (p_por_width)
      else $error("power-on reset too short");
   property p_warm_width;
      $fell(reset_n) |-> !reset_n [*8];
   endproperty
   a_warm_width: assert property (p_warm_width)
      else $error("warm reset too short");
   property p_ready_wait;
      $rose(reset_n) |-> cs_n [*6];
   endproperty
   a_ready_wait: assert property (p_ready_wait)
      else $error("access before ready time");
   property p_wr_strobe;
      $fell(write_control_in_n) |-> !cs_n throughout
         (!write_control_in_n [*2] ##1 write_control_in_n);
   endproperty
   a_wr_strobe: assert property (p_wr_strobe)
      else $error("write strobe shape wrong");
   c_write: cover property ($fell(write_control_in_n));
   c_read: cover property ($fell(read_control_in_n) ##1 rdata_oe);
   c_warm: cover property ($fell(reset_n));
endmodule // prc_link_chk
`default_nettype wire

// *** sim/tb_pld_power_reset_isp_ctrl.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "prc_defs.svh"
module tb_pld_power_reset_isp_ctrl;
   import prc_pkg::*;
   typedef struct packed {
      prc_byte_t addr;
      prc_byte_t wdata;
      prc_byte_t exp;
   } prc_row_s;
   logic      clk_sys, rst_n, cmd_req, cmd_we, warm_req, cmd_ready, cmd_done;
   logic      pld_clk, pd_zero, cfg_jtag, jtag_term, turbo_on, array_clk;
   logic      pld_rd_n, pld_pdz, pld_pc7, out_valid, rd_array, jtag_on;
   logic      flash_rd_n, flash_wr_n, pld_wr_n, flash_sel, flash_stby;
   logic      dev_ready, prog_ext, prog_stat_n;
   prc_byte_t cmd_addr, cmd_wdata, cmd_rdata, portc_in, mc_rst, mc_pre;
   prc_byte_t portc_oe, mcell_q, mc_d, portc_out;
   int        fails, n_compared;
   prc_row_s  rows [4] = '{
      '{`PRC_OFS_PMR0, 8'hFF, `PRC_PMR0_MASK},
      '{`PRC_OFS_GATE, 8'hFF, `PRC_GATE_MASK},
      '{`PRC_OFS_JTAG, 8'h01, 8'h01},
      '{8'h40, 8'h5A, 8'h00}};
   prc_bus_if prc_bus_if_inst ();
   prc_dev_end prc_dev_end_inst (.CLK_SYS(clk_sys), .RST_N(rst_n),
      .BUS(prc_bus_if_inst), .PLD_CLOCK_INPUT(pld_clk),
      .PORTD_PIN_ZERO(pd_zero), .PORTC_IN(portc_in), .CFG_JTAG_PINS(cfg_jtag),
      .PLD_JTAG_TERM(jtag_term), .PROG_EXT_EN(prog_ext),
      .PROG_STATUS_N(prog_stat_n), .PROG_ERROR_N(1'b1), .MCELL_D(mc_d),
      .MCELL_RESET(mc_rst), .MCELL_PRESET(mc_pre), .PORTC_OUT_0(),
      .PORTC_OUT(portc_out), .PORTC_OE(portc_oe),
      .PLD_WRITE_CTL_N(pld_wr_n), .PLD_READ_CTL_N(pld_rd_n),
      .PLD_THIRD_CTL(), .PLD_PORTD_ZERO(pld_pdz), .PLD_PORTC_SEVEN(pld_pc7),
      .PLD_ARRAY_CLK(array_clk), .PLD_TURBO_ON(turbo_on),
      .PLD_OUT_VALID(out_valid), .MCELL_Q(mcell_q), .FLASH_SEL(flash_sel),
      .FLASH_STANDBY(flash_stby), .FLASH_WR_N(flash_wr_n),
      .FLASH_RD_N(flash_rd_n), .FLASH_READ_ARRAY(rd_array),
      .JTAG_ON(jtag_on), .DEV_READY(dev_ready));
   prc_host_end prc_host_end_inst (.CLK_SYS(clk_sys), .RST_N(rst_n),
      .BUS(prc_bus_if_inst), .CMD_REQ(cmd_req), .CMD_WE(cmd_we),
      .CMD_ADDR(cmd_addr), .CMD_WDATA(cmd_wdata), .WARM_REQ(warm_req),
      .CMD_READY(cmd_ready), .CMD_DONE(cmd_done), .CMD_RDATA(cmd_rdata));
   prc_link_chk prc_link_chk_inst (.CLK_SYS(clk_sys), .RST_N(rst_n),
      .reset_n(prc_bus_if_inst.reset_n), .cs_n(prc_bus_if_inst.cs_n),
      .write_control_in_n(prc_bus_if_inst.write_control_in_n),
      .read_control_in_n(prc_bus_if_inst.read_control_in_n),
      .rdata_oe(prc_bus_if_inst.rdata_oe),
      .flash_sector_selects(prc_bus_if_inst.flash_sector_selects));
   task automatic wrap_up();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input prc_byte_t seen, exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   // 0 ready, 1 done, 2 flash strobe
   task automatic wait_on(input int sel);
      int n;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (!((sel == 0 && cmd_ready === 1'b1) ||
         (sel == 1 && cmd_done === 1'b1) ||
         (sel == 2 && (flash_rd_n & flash_wr_n) === 1'b0)) && n < 300);
      if (n >= 300) begin
         fails++;
         $display("MISMATCH wait %0d exp event seen none", sel);
         wrap_up();
      end
   endtask
   task automatic acc(input logic we, input prc_byte_t a, d,
      input logic look, input logic exp_rd_n);
      wait_on(0);
      cmd_req   <= 1'b1;
      cmd_we    <= we;
      cmd_addr  <= a;
      cmd_wdata <= d;
      @(posedge clk_sys);
      cmd_req <= 1'b0;
      if (look) begin
         wait_on(2);
         chk("pld_ctl_n", we ? pld_wr_n : pld_rd_n, exp_rd_n);
         chk("flash_sel", flash_sel, 8'h01);
      end
      wait_on(1);
   endtask
   task automatic rd(input string nm, input prc_byte_t a, exp);
      acc(1'b0, a, 8'h00, 1'b0, 1'b0);
      chk(nm, cmd_rdata, exp);
   endtask
   task automatic mc_tick(input prc_byte_t d);
      mc_d    <= d;
      pld_clk <= 1'b0;
      repeat (2) @(posedge clk_sys);
      pld_clk <= 1'b1;
      repeat (2) @(posedge clk_sys);
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   initial begin
      {rst_n, cmd_req, cmd_we, warm_req, pld_clk, pd_zero, jtag_term,
       prog_ext, prog_stat_n} = 9'h000;
      {cmd_addr, cmd_wdata, portc_in, mc_rst, mc_pre, mc_d} =
         48'h0000_0000_0000;
      cfg_jtag = 1'b1;
      fails = 0;
      n_compared = 0;
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk_sys);
      chk("out_valid_por", out_valid, 8'h00);
      chk("read_array", rd_array, 8'h01);
      chk("mcell_por", mcell_q, 8'h00);
      chk("jtag_blank", jtag_on, 8'h01);
      cfg_jtag <= 1'b0;
      $display("test reset done");
      foreach (rows[i]) begin
         acc(1'b1, rows[i].addr, rows[i].wdata, 1'b0, 1'b0);
         rd("row", rows[i].addr, rows[i].exp);
      end
      chk("jtag_reg", jtag_on, 8'h01);
      $display("test registers done");
      pld_clk  <= 1'b1;
      pd_zero  <= 1'b1;
      portc_in <= 8'h80;
      acc(1'b0, `PRC_OFS_PMR0, 8'h00, 1'b1, 1'b1);
      chk("turbo_off", turbo_on, 8'h00);
      chk("array_clk_blk", array_clk, 8'h00);
      chk("pdz_blk", pld_pdz, 8'h00);
      chk("pc7_blk", pld_pc7, 8'h00);
      chk("standby", flash_stby, 8'h01);
      acc(1'b1, `PRC_OFS_PMR0, 8'hFF, 1'b1, 1'b1);
      acc(1'b1, `PRC_OFS_PMR0, 8'h00, 1'b0, 1'b0);
      acc(1'b1, `PRC_OFS_GATE, 8'h00, 1'b0, 1'b0);
      acc(1'b0, `PRC_OFS_PMR0, 8'h00, 1'b1, 1'b0);
      chk("turbo_on", turbo_on, 8'h01);
      chk("array_clk", array_clk, 8'h01);
      chk("pdz_pass", pld_pdz, 8'h01);
      chk("pc7_pass", pld_pc7, 8'h01);
      mc_tick(8'hA5);
      chk("mcell_clk", mcell_q, 8'hA5);
      $display("test blocking done");
      acc(1'b1, `PRC_OFS_PMR0, 8'hFF, 1'b0, 1'b0);
      mc_tick(8'h5A);
      chk("mcell_blk", mcell_q, 8'hA5);
      acc(1'b1, `PRC_OFS_GATE, 8'hFF, 1'b0, 1'b0);
      acc(1'b1, `PRC_OFS_GPIO_DIR, 8'hFF, 1'b0, 1'b0);
      mc_rst <= 8'h0F;
      mc_pre <= 8'hFF;
      wait_on(0);
      warm_req <= 1'b1;
      @(posedge clk_sys);
      warm_req <= 1'b0;
      repeat (12) begin
         @(posedge clk_sys);
         chk("valid_warm", out_valid, 8'h01);
      end
      chk("ready_warm", dev_ready, 8'h00);
      rd("pmr0_warm", `PRC_OFS_PMR0, `PRC_PMR0_MASK);
      rd("gate_warm", `PRC_OFS_GATE, `PRC_GATE_MASK);
      rd("jtag_warm", `PRC_OFS_JTAG, 8'h00);
      chk("jtag_off", jtag_on, 8'h00);
      chk("oe_warm", portc_oe, 8'h00);
      chk("mcell_warm", mcell_q, 8'hF0);
      jtag_term <= 1'b1;
      repeat (2) @(posedge clk_sys);
      chk("jtag_term", jtag_on, 8'h01);
      prog_ext    <= 1'b1;
      prog_stat_n <= 1'b0;
      for (int b = 0; b < 2; b++) begin
         portc_in <= 8'(b << `PRC_PIN_TDI);
         repeat (2) @(posedge clk_sys);
         portc_in <= 8'(b << `PRC_PIN_TDI) | 8'h02;
         repeat (2) @(posedge clk_sys);
         portc_in <= 8'(b << `PRC_PIN_TDI);
         repeat (3) @(posedge clk_sys);
         chk("tdo", {portc_oe[`PRC_PIN_TDO], portc_out[`PRC_PIN_TDO]},
             8'(b + 2));
      end
      chk("prog_ext_oe", portc_oe, 8'h48);
      jtag_term <= 1'b0;
      $display("test warm reset done");
      rst_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk_sys);
      chk("mcell_por2", mcell_q, 8'h00);
      rd("pmr0_por", `PRC_OFS_PMR0, 8'h00);
      rd("gate_por", `PRC_OFS_GATE, 8'h00);
      $display("test power-on reset done");
      wrap_up();
   end
endmodule // tb_pld_power_reset_isp_ctrl
`default_nettype wire
